// ==== bsr_bus_ctrl.sv ====
// Bus cycle sequencer with reset synchronisation and reset straps.
`timescale 1ns/1ps
`default_nettype none
`include "bsr_regs.svh"
module bsr_bus_ctrl (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        hold_req,
    output logic             hold_ack,
    input  wire logic        cyc_req,
    output logic             cyc_ready,
    input  wire logic [2:0]  cyc_kind,
    input  wire logic        cyc_dma,
    input  wire logic        cyc_refresh,
    input  wire logic [19:0] cyc_addr,
    input  wire logic [15:0] cyc_wdata,
    output logic      [15:0] cyc_rdata,
    output logic             cyc_done,
    input  wire logic        srdy,
    input  wire logic        ardy,
    input  wire logic [15:0] ad_i,
    output logic      [15:0] ad_o,
    output logic             ad_oe,
    output logic      [19:0] addr_o,
    output logic             addr_oe,
    output logic             ale,
    output logic             rd_n_o,
    output logic             rd_oe,
    output logic             wr_n_o,
    output logic             wr_oe,
    output logic      [2:0]  cycle_status_code_o,
    output logic             cycle_status_code_oe,
    output logic             dma_cycle_flag_o,
    output logic             dma_cycle_flag_oe,
    input  wire logic        vector_zone_n_i,
    output logic             vector_zone_n_o,
    output logic             vector_zone_n_oe,
    input  wire logic        aden_strap_i,
    output logic             refresh_indicator_low_o,
    output logic             refresh_indicator_low_oe,
    input  wire logic        half_clock_strap,
    input  wire logic        emul_strap_a,
    input  wire logic        emul_strap_b,
    input  wire logic        psram_mode,
    output logic             midrange_select_refresh,
    output logic             upper_select_n,
    output logic             lower_select_n,
    output logic             select_oe,
    input  wire logic        cs_cfg_wr,
    input  wire logic [1:0]  ucs_size_code,
    input  wire logic [1:0]  lcs_size_code,
    input  wire logic        ucs_addr_only_select,
    input  wire logic        lcs_addr_only_select,
    output logic             half_clock_mode,
    output logic             emul_float,
    output logic             clock_test_mode,
    output logic             pins_normal_fn,
    output logic             fetch_start,
    output logic      [19:0] fetch_addr,
    output logic             core_reset
);
    bsr_pkg::bsr_state_t state_reg;
    bsr_pkg::bsr_state_t state_next;
    logic        rst_core;
    logic        rst_prev_reg;
    logic        cap_main;
    logic        cap_aden_reg;
    logic        ardy_sync;
    logic        aden_high;
    logic [3:0]  straps_val;
    logic [3:0]  fetch_cnt_reg;
    logic        run_reg;
    logic [1:0]  ucs_size_reg;
    logic [1:0]  lcs_size_reg;
    logic        ucs_ao_reg;
    logic        lcs_ao_reg;
    logic        lcs_en_reg;
    logic [2:0]  kind_reg;
    logic        dma_reg;
    logic        ref_reg;
    logic        ao_reg;
    logic        ucs_hit_reg;
    logic        lcs_hit_reg;
    logic [19:0] addr_reg;
    logic [15:0] wdata_reg;
    logic        accept;
    logic        ready;
    logic        is_mem;
    logic        is_rd;
    logic        is_wr;
    logic [3:0]  ucs_mask;
    logic [3:0]  lcs_mask;
    logic        ucs_hit;
    logic        lcs_hit;
    logic        in_cyc_next;
    logic        drive_ok;
    logic        ao_new;
    logic        ao_cur;
    logic [2:0]  kind_cur;
    logic        ref_cur;
    logic        ucs_cur;
    logic        lcs_cur;
    logic [19:0] addr_cur;

    // Reset is asserted at once and released only on a clock edge.
    bsr_sync2 #(
        .RST_VAL(1'b1)
    ) u_rst_sync (
        .mclk(mclk),
        .rst (rst),
        .d   (1'b0),
        .q   (rst_core)
    );

    bsr_sync2 #(
        .RST_VAL(1'b0)
    ) u_ardy_sync (
        .mclk(mclk),
        .rst (rst_core),
        .d   (ardy),
        .q   (ardy_sync)
    );

    assign core_reset = rst_core;
    assign fetch_addr = `BSR_RESET_VEC;

    always_ff @(posedge mclk or posedge rst_core) begin
        if (rst_core) begin
            rst_prev_reg <= 1'b1;
            cap_aden_reg <= 1'b0;
        end else begin
            rst_prev_reg <= 1'b0;
            cap_aden_reg <= cap_main;
        end
    end

    assign cap_main = rst_prev_reg;

    // Order: half clock, emulation a, emulation b, vector zone pin.
    bsr_strap_latch #(
        .W      (4),
        .RST_VAL(4'hF)
    ) u_straps (
        .mclk   (mclk),
        .rst    (rst_core),
        .capture(cap_main),
        .pins   ({half_clock_strap, emul_strap_a, emul_strap_b,
                  vector_zone_n_i}),
        .value  (straps_val)
    );

    bsr_strap_latch #(
        .W      (1),
        .RST_VAL(1'b1)
    ) u_aden (
        .mclk   (mclk),
        .rst    (rst_core),
        .capture(cap_aden_reg),
        .pins   (aden_strap_i),
        .value  (aden_high)
    );

    assign half_clock_mode = ~straps_val[3];
    assign emul_float      = ~straps_val[2] & ~straps_val[1];
    assign clock_test_mode = ~straps_val[0];
    assign pins_normal_fn  = ~aden_high;

    // The core may fetch only after the release delay has run out.
    always_ff @(posedge mclk or posedge rst_core) begin
        if (rst_core) begin
            fetch_cnt_reg <= 4'h0;
            run_reg       <= 1'b0;
            fetch_start   <= 1'b0;
        end else begin
            fetch_start <= 1'b0;
            if (!run_reg) begin
                fetch_cnt_reg <= fetch_cnt_reg + 4'h1;
                if (fetch_cnt_reg == 4'(`BSR_FETCH_CYC - 1)) begin
                    run_reg     <= 1'b1;
                    fetch_start <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst_core) begin
        if (rst_core) begin
            ucs_size_reg <= `BSR_UCS_SIZE_RST;
            lcs_size_reg <= `BSR_LCS_SIZE_RST;
            ucs_ao_reg   <= `BSR_AO_RST;
            lcs_ao_reg   <= `BSR_AO_RST;
            lcs_en_reg   <= 1'b0;
        end else if (cs_cfg_wr) begin
            ucs_size_reg <= ucs_size_code;
            lcs_size_reg <= lcs_size_code;
            ucs_ao_reg   <= ucs_addr_only_select;
            lcs_ao_reg   <= lcs_addr_only_select;
            lcs_en_reg   <= 1'b1;
        end
    end

    // Upper block ends at the top of memory; lower starts at zero.
    assign ucs_mask = 4'hF << ucs_size_reg;
    assign lcs_mask = 4'hF << lcs_size_reg;
    assign is_mem   = cyc_kind[2] & (cyc_kind != bsr_pkg::BSR_ST_PASSIVE);
    assign ucs_hit  = is_mem & ((cyc_addr[19:16] & ucs_mask) == ucs_mask);
    assign lcs_hit  = is_mem & lcs_en_reg
                    & ((cyc_addr[19:16] & lcs_mask) == 4'h0);

    assign accept    = (state_reg == bsr_pkg::BSR_IDLE) & cyc_req & run_reg
                     & ~hold_req & ~emul_float;
    assign cyc_ready = (state_reg == bsr_pkg::BSR_IDLE) & run_reg
                     & ~hold_req & ~emul_float;
    assign ready     = srdy | ardy_sync;
    assign is_rd     = (kind_reg == bsr_pkg::BSR_ST_INTA)
                     | (kind_reg == bsr_pkg::BSR_ST_IO_RD)
                     | (kind_reg == bsr_pkg::BSR_ST_FETCH)
                     | (kind_reg == bsr_pkg::BSR_ST_MEM_RD);
    assign is_wr     = (kind_reg == bsr_pkg::BSR_ST_IO_WR)
                     | (kind_reg == bsr_pkg::BSR_ST_MEM_WR);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            bsr_pkg::BSR_IDLE: begin
                if (hold_req && !emul_float) begin
                    state_next = bsr_pkg::BSR_HOLD;
                end else if (accept) begin
                    state_next = bsr_pkg::BSR_T1;
                end
            end
            bsr_pkg::BSR_T1: state_next = bsr_pkg::BSR_T2;
            bsr_pkg::BSR_T2: state_next = bsr_pkg::BSR_T3;
            bsr_pkg::BSR_T3,
            bsr_pkg::BSR_TW: begin
                state_next = ready ? bsr_pkg::BSR_T4 : bsr_pkg::BSR_TW;
            end
            bsr_pkg::BSR_T4: state_next = bsr_pkg::BSR_IDLE;
            bsr_pkg::BSR_HOLD: begin
                if (!hold_req) begin
                    state_next = bsr_pkg::BSR_IDLE;
                end
            end
            default: state_next = bsr_pkg::BSR_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst_core) begin
        if (rst_core) begin
            state_reg <= bsr_pkg::BSR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Cycle attributes are frozen when the cycle is accepted.
    always_ff @(posedge mclk or posedge rst_core) begin
        if (rst_core) begin
            kind_reg    <= bsr_pkg::BSR_ST_PASSIVE;
            dma_reg     <= 1'b0;
            ref_reg     <= 1'b0;
            ao_reg      <= 1'b0;
            ucs_hit_reg <= 1'b0;
            lcs_hit_reg <= 1'b0;
            addr_reg    <= 20'h00000;
            wdata_reg   <= 16'h0000;
        end else if (accept) begin
            kind_reg    <= cyc_kind;
            dma_reg     <= cyc_dma;
            ref_reg     <= cyc_refresh;
            ao_reg      <= ao_new;
            ucs_hit_reg <= ucs_hit;
            lcs_hit_reg <= lcs_hit;
            addr_reg    <= cyc_addr;
            wdata_reg   <= cyc_wdata;
        end
    end

    assign in_cyc_next = (state_next == bsr_pkg::BSR_T1)
                       | (state_next == bsr_pkg::BSR_T2)
                       | (state_next == bsr_pkg::BSR_T3)
                       | (state_next == bsr_pkg::BSR_TW)
                       | (state_next == bsr_pkg::BSR_T4);

    assign ao_new = aden_high
                  & ((ucs_hit & ucs_ao_reg)
                  | (lcs_hit & ~ucs_hit & lcs_ao_reg));

    // On the accept edge the registers still hold the previous cycle.
    assign ao_cur   = accept ? ao_new : ao_reg;
    assign kind_cur = accept ? cyc_kind : kind_reg;
    assign ref_cur  = accept ? cyc_refresh : ref_reg;
    assign ucs_cur  = accept ? ucs_hit : ucs_hit_reg;
    assign lcs_cur  = accept ? lcs_hit : lcs_hit_reg;
    assign addr_cur = accept ? cyc_addr : addr_reg;

    // Strobes and codes are registered from the next state.
    always_ff @(posedge mclk or posedge rst_core) begin
        if (rst_core) begin
            ale                     <= 1'b0;
            ad_o                    <= 16'h0000;
            ad_oe                   <= 1'b0;
            rd_n_o                  <= 1'b1;
            wr_n_o                  <= 1'b1;
            cycle_status_code_o     <= bsr_pkg::BSR_ST_PASSIVE;
            dma_cycle_flag_o        <= 1'b0;
            vector_zone_n_o         <= 1'b1;
            refresh_indicator_low_o <= 1'b1;
            midrange_select_refresh <= 1'b1;
            upper_select_n          <= 1'b1;
            lower_select_n          <= 1'b1;
            cyc_done                <= 1'b0;
            cyc_rdata               <= 16'h0000;
        end else begin
            ale    <= (state_next == bsr_pkg::BSR_T1);
            ad_oe  <= ((state_next == bsr_pkg::BSR_T1) & ~ao_cur)
                    | (in_cyc_next & (state_next != bsr_pkg::BSR_T1)
                       & is_wr);
            ad_o   <= (state_next == bsr_pkg::BSR_T1) ? addr_cur[15:0]
                                                     : wdata_reg;
            // The bus is floated at T2, the read strobe follows at T3.
            rd_n_o <= ~(is_rd & ((state_next == bsr_pkg::BSR_T3)
                               | (state_next == bsr_pkg::BSR_TW)));
            wr_n_o <= ~(is_wr & ((state_next == bsr_pkg::BSR_T2)
                               | (state_next == bsr_pkg::BSR_T3)
                               | (state_next == bsr_pkg::BSR_TW)));
            cycle_status_code_o <= (in_cyc_next
                                    & (state_next != bsr_pkg::BSR_T4))
                                   ? kind_cur
                                   : bsr_pkg::BSR_ST_PASSIVE;
            dma_cycle_flag_o <= dma_reg & in_cyc_next
                              & (state_next != bsr_pkg::BSR_T1);
            vector_zone_n_o  <= in_cyc_next
                              ? (|(~addr_cur[19:16]))
                              : 1'b1;
            refresh_indicator_low_o <= ~(ref_cur & ~psram_mode
                                         & in_cyc_next);
            midrange_select_refresh <= ~(ref_cur & psram_mode & in_cyc_next);
            upper_select_n <= ~(ucs_cur & in_cyc_next);
            lower_select_n <= ~(lcs_cur & ~ucs_cur & in_cyc_next);
            cyc_done <= (state_next == bsr_pkg::BSR_T4);
            if (state_next == bsr_pkg::BSR_T4 && is_rd) begin
                cyc_rdata <= ad_i;
            end
        end
    end

    assign hold_ack = (state_reg == bsr_pkg::BSR_HOLD);
    assign addr_o   = addr_reg;
    assign drive_ok = ~emul_float & ~hold_ack;

    assign addr_oe              = drive_ok & ~rst_core;
    assign select_oe            = ~emul_float;
    assign rd_oe                = drive_ok;
    assign wr_oe                = drive_ok & ~rst_core;
    assign cycle_status_code_oe = drive_ok;
    assign dma_cycle_flag_oe    = drive_ok & ~rst_core
                                & pins_normal_fn;
    assign vector_zone_n_oe     = ~emul_float & ~rst_core & pins_normal_fn;
    assign refresh_indicator_low_oe = drive_ok & ~rst_core;
endmodule
`default_nettype wire

// ==== bsr_bus_ctrl_asserts.sv ====
// Concurrent checks on the ports of the bus sequencer.
`timescale 1ns/1ps
`default_nettype none
module bsr_bus_ctrl_asserts (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        core_reset,
    input wire logic        fetch_start,
    input wire logic        hold_ack,
    input wire logic        cyc_req,
    input wire logic        cyc_ready,
    input wire logic [2:0]  cyc_kind,
    input wire logic        cyc_done,
    input wire logic [2:0]  cycle_status_code_o,
    input wire logic        cycle_status_code_oe,
    input wire logic        ale,
    input wire logic        ad_oe,
    input wire logic        rd_n_o,
    input wire logic        rd_oe,
    input wire logic        wr_oe,
    input wire logic        dma_cycle_flag_oe,
    input wire logic        upper_select_n,
    input wire logic [19:0] addr_o,
    input wire logic        vector_zone_n_o,
    input wire logic        vector_zone_n_oe,
    input wire logic        select_oe,
    input wire logic        emul_float,
    input wire logic        half_clock_mode,
    input wire logic        clock_test_mode,
    input wire logic        pins_normal_fn
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    reset_hold_a: assert property (disable iff (1'b0) rst |-> core_reset)
        else $error("core reset low during reset");
    reset_sync_a: assert property ($fell(rst) |-> core_reset ##[1:3] !core_reset)
        else $error("reset release not synchronised");
    fetch_gap_a: assert property ($fell(core_reset) |-> !fetch_start[*4])
        else $error("fetch started too early");
    ready_block_a: assert property ((core_reset || hold_ack || emul_float) |-> !cyc_ready)
        else $error("cycle accepted while blocked");
    status_kind_a: assert property (cyc_req && cyc_ready |=> ale && cycle_status_code_o == $past(cyc_kind))
        else $error("status code differs from cycle kind");
    passive_done_a: assert property (cyc_done |-> cycle_status_code_o == 3'h7)
        else $error("status not passive at cycle end");
    hold_float_a: assert property (hold_ack |-> !cycle_status_code_oe && !rd_oe && !wr_oe && !dma_cycle_flag_oe && upper_select_n)
        else $error("pins driven in bus hold");
    read_float_a: assert property ($fell(rd_n_o) |-> !ad_oe && !$past(ad_oe))
        else $error("read strobe before bus release");
    vector_zone_a: assert property (ale |-> vector_zone_n_o == |(~addr_o[19:16]))
        else $error("vector zone flag wrong");
    emul_float_a: assert property (emul_float |-> !select_oe && !rd_oe && !cycle_status_code_oe && !ad_oe)
        else $error("pin driven in float mode");
    straps_held_a: assert property (!core_reset [*5] |-> $stable({half_clock_mode, emul_float, clock_test_mode, pins_normal_fn}))
        else $error("strap value changed");
    normal_fn_a: assert property (!pins_normal_fn |-> !dma_cycle_flag_oe && !vector_zone_n_oe)
        else $error("flag pins driven as normal");
    mux_addr_a: assert property (pins_normal_fn && ale |-> ad_oe)
        else $error("address missing on shared bus");
endmodule
bind bsr_bus_ctrl bsr_bus_ctrl_asserts chk (.mclk, .rst, .core_reset, .fetch_start,
    .hold_ack, .cyc_req, .cyc_ready, .cyc_kind, .cyc_done, .cycle_status_code_o,
    .cycle_status_code_oe, .ale, .ad_oe, .rd_n_o, .rd_oe, .wr_oe,
    .dma_cycle_flag_oe, .upper_select_n, .addr_o, .vector_zone_n_o,
    .vector_zone_n_oe, .select_oe, .emul_float, .half_clock_mode,
    .clock_test_mode, .pins_normal_fn);
`default_nettype wire

// ==== bsr_mem_model.sv ====
// Behavioural memory and I/O device on the far side of the bus.
`timescale 1ns/1ps
`default_nettype none
module bsr_mem_model (
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic        ale,
    input  wire logic [19:0] addr_o,
    input  wire logic [15:0] ad_o,
    input  wire logic        rd_n_o,
    input  wire logic        wr_n_o,
    output logic      [15:0] ad_i,
    output logic             srdy,
    output logic             ardy
);
    logic [15:0] mem [16];
    logic [3:0]  idx;
    logic [15:0] last = 16'h0000;
    int          low_cnt = 0;
    // A slow device leaves sync ready low and answers late on async ready.
    assign srdy = !slow;
    // A released bus shows the inverse of the last word, never a stale copy.
    assign ad_i = rd_n_o ? ~last : mem[idx];
    always @(posedge mclk) begin
        if (ale) begin
            idx <= addr_o[4:1];
        end
        if (!wr_n_o) begin
            mem[idx] <= ad_o;
        end
        if (!rd_n_o) begin
            last <= mem[idx];
        end
        low_cnt <= (rd_n_o && wr_n_o) ? 0 : low_cnt + 1;
        ardy <= slow && low_cnt >= 3;
    end
endmodule
`default_nettype wire

// ==== bsr_pkg.sv ====
// Types of the bus status, reset and strap block.
package bsr_pkg;
    typedef enum logic [2:0] {
        BSR_ST_INTA    = 3'h0,
        BSR_ST_IO_RD   = 3'h1,
        BSR_ST_IO_WR   = 3'h2,
        BSR_ST_HALT    = 3'h3,
        BSR_ST_FETCH   = 3'h4,
        BSR_ST_MEM_RD  = 3'h5,
        BSR_ST_MEM_WR  = 3'h6,
        BSR_ST_PASSIVE = 3'h7
    } bsr_status_t;
    typedef enum logic [6:0] {
        BSR_IDLE = 7'h01,
        BSR_T1   = 7'h02,
        BSR_T2   = 7'h04,
        BSR_T3   = 7'h08,
        BSR_TW   = 7'h10,
        BSR_T4   = 7'h20,
        BSR_HOLD = 7'h40
    } bsr_state_t;
endpackage

// ==== bsr_regs.svh ====
// Constants of the bus status, reset and strap block.
`ifndef BSR_REGS_SVH
`define BSR_REGS_SVH
`define BSR_RESET_VEC      20'hFFFF0
`define BSR_FETCH_HALF_PER 13
`define BSR_FETCH_CYC      ((`BSR_FETCH_HALF_PER + 1) / 2)
`define BSR_UCS_SIZE_RST   2'h0
`define BSR_LCS_SIZE_RST   2'h0
`define BSR_AO_RST         1'b0
`endif

// ==== bsr_strap_latch.sv ====
// Strap latch that captures its pins once per reset and then holds.
`timescale 1ns/1ps
`default_nettype none
module bsr_strap_latch #(
    parameter int        W       = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         capture,
    input  wire logic [W-1:0] pins,
    output logic      [W-1:0] value
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            value <= RST_VAL;
        end else if (capture) begin
            value <= pins;
        end
    end
endmodule
`default_nettype wire

// ==== bsr_sync2.sv ====
// Two-stage synchroniser with asynchronous reset to a fixed level.
`timescale 1ns/1ps
`default_nettype none
module bsr_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ==== test_bus_status_reset_straps.sv ====
// Self-checking bench for the bus sequencer, reset and strap capture.
`timescale 1ns/1ps
`default_nettype none
module test_bus_status_reset_straps;
    logic        mclk, rst, hold_req, hold_ack, cyc_req, cyc_ready, cyc_dma;
    logic        cyc_refresh, cyc_done, srdy, ardy, ad_oe, addr_oe, ale;
    logic        rd_n_o, rd_oe, wr_n_o, wr_oe, cycle_status_code_oe, slow;
    logic        dma_cycle_flag_o, dma_cycle_flag_oe, vector_zone_n_i;
    logic        vector_zone_n_o, vector_zone_n_oe, aden_strap_i;
    logic        refresh_indicator_low_o, refresh_indicator_low_oe;
    logic        half_clock_strap, emul_strap_a, emul_strap_b, psram_mode;
    logic        midrange_select_refresh, upper_select_n, lower_select_n;
    logic        select_oe, cs_cfg_wr, ucs_addr_only_select, core_reset;
    logic        lcs_addr_only_select, half_clock_mode, emul_float;
    logic        clock_test_mode, pins_normal_fn, fetch_start;
    logic [1:0]  ucs_size_code, lcs_size_code;
    logic [2:0]  cyc_kind, cycle_status_code_o, t1_st;
    logic [15:0] cyc_wdata, cyc_rdata, ad_i, ad_o, rdat;
    logic [19:0] cyc_addr, addr_o, fetch_addr;
    logic        t1_ad_oe, t1_ucs, t1_rfsh, t1_mid, t1_dma, t2_dma;
    int          failures, samples_checked, n;

    bsr_bus_ctrl dut (.*);
    bsr_mem_model far (.*);

    always #50 mclk = ~mclk;

    task automatic chk(input string what, input logic [19:0] e, input logic [19:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic give_verdict;
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic cfg_write;
        cs_cfg_wr = 1'b1;
        tick(1);
        cs_cfg_wr = 1'b0;
    endtask

    // Strap order: half clock, emulation a, emulation b, vector zone, aden.
    task automatic do_reset(input logic [4:0] s);
        {half_clock_strap, emul_strap_a, emul_strap_b, vector_zone_n_i, aden_strap_i} = s;
        rst = 1'b1;
        tick(20);
        chk("reset status", 20'h7, 20'(cycle_status_code_o));
        chk("reset dma oe", 20'h0, 20'(dma_cycle_flag_oe));
        rst = 1'b0;
        n = 0;
        while (fetch_start !== 1'b1 && n < 30) begin
            tick(1);
            n++;
        end
        {half_clock_strap, emul_strap_a, emul_strap_b, vector_zone_n_i, aden_strap_i} = 5'h1E;
    endtask

    task automatic do_cycle(input logic [2:0] k, input logic [19:0] a, input logic [15:0] w, input logic d);
        {cyc_kind, cyc_addr, cyc_wdata, cyc_dma} = {k, a, w, d};
        cyc_req = 1'b1;
        n = 0;
        while (cyc_ready !== 1'b1 && n < 30) begin
            tick(1);
            n++;
        end
        tick(1);
        cyc_req = 1'b0;
        {t1_st, t1_ad_oe, t1_ucs, t1_rfsh, t1_mid, t1_dma} = {cycle_status_code_o,
            ad_oe, upper_select_n, refresh_indicator_low_o, midrange_select_refresh, dma_cycle_flag_o};
        tick(1);
        t2_dma = dma_cycle_flag_o;
        n = 0;
        while (cyc_done !== 1'b1 && n < 30) begin
            tick(1);
            n++;
        end
        chk("cycle done", 20'h1, 20'(cyc_done));
        rdat = cyc_rdata;
        tick(1);
    endtask

    initial begin
        #500000;
        failures++;
        give_verdict;
    end

    initial begin
        {mclk, hold_req, cyc_req, cyc_dma, cyc_refresh, psram_mode, cs_cfg_wr, slow} = '0;
        {cyc_kind, cyc_addr, cyc_wdata, ucs_size_code, lcs_size_code} = '0;
        {ucs_addr_only_select, lcs_addr_only_select} = '0;
        do_reset(5'h1E);
        chk("fetch delay", 20'h1, 20'(n >= 6 && n <= 10));
        chk("fetch address", 20'hFFFF0, fetch_addr);
        chk("strap modes", 20'h1, 20'({half_clock_mode, emul_float, clock_test_mode, pins_normal_fn}));
        for (int k = 0; k < 8; k++) begin
            do_cycle(k[2:0], 20'hF0000 + 20'(k * 2), 16'hA5C0 + 16'(k), 1'b0);
            chk("status", 20'(k), 20'(t1_st));
            chk("upper select", 20'(k < 4 || k == 7), 20'(t1_ucs));
        end
        do_cycle(3'h1, 20'hF0004, 16'h0000, 1'b0);
        chk("io read", 20'hA5C2, 20'(rdat));
        chk("ready wait", 20'h2, 20'(n));
        slow = 1'b1;
        do_cycle(3'h5, 20'hF000C, 16'h0000, 1'b0);
        chk("slow read", 20'hA5C6, 20'(rdat));
        chk("slow wait", 20'h1, 20'(n > 2));
        slow = 1'b0;
        for (int s = 0; s < 4; s++) begin
            ucs_size_code = s[1:0];
            cfg_write();
            do_cycle(3'h5, 20'(32'h100000 - (32'h10000 << s)), 16'h0000, 1'b0);
            chk("upper base", 20'h0, 20'(t1_ucs));
            do_cycle(3'h5, 20'(32'hFFFFE - (32'h10000 << s)), 16'h0000, 1'b0);
            chk("below upper", 20'h1, 20'(t1_ucs));
        end
        do_cycle(3'h6, 20'h00010, 16'h1234, 1'b1);
        chk("dma first period", 20'h1, 20'({t1_dma, dma_cycle_flag_oe}));
        chk("dma second period", 20'h1, 20'(t2_dma));
        cyc_refresh = 1'b1;
        for (int p = 0; p < 2; p++) begin
            psram_mode = p[0];
            do_cycle(3'h5, 20'h00020, 16'h0000, 1'b0);
            chk("refresh pins", 20'(p ? 2'b10 : 2'b01), 20'({t1_rfsh, t1_mid}));
        end
        cyc_refresh = 1'b0;
        hold_req = 1'b1;
        tick(3);
        chk("hold pins", 20'h10, 20'({hold_ack, cycle_status_code_oe, rd_oe,
            refresh_indicator_low_oe, cyc_ready}));
        chk("hold upper", 20'h1, 20'(upper_select_n));
        hold_req = 1'b0;
        tick(2);
        do_reset(5'h05);
        chk("strap modes", 20'hA, 20'({half_clock_mode, emul_float, clock_test_mode, pins_normal_fn}));
        for (int c = 0; c < 3; c++) begin
            do_reset({4'hF, c < 2});
            ucs_size_code = 2'h0;
            ucs_addr_only_select = (c != 1);
            cfg_write();
            do_cycle(3'h5, 20'hFFFF0, 16'h0000, 1'b0);
            chk("address phase drive", 20'(c != 0), 20'(t1_ad_oe));
        end
        do_reset(5'h12);
        tick(3);
        chk("float mode", 20'h4, 20'({emul_float, select_oe, rd_oe}));
        do_reset(5'h1A);
        chk("one emulation strap", 20'h0, 20'(emul_float));
        give_verdict;
    end
endmodule
`default_nettype wire
